/* design/orient_pkg.sv */
// Purpose: Shared constants and helpers for the orientation detection engine.
// Assumes: 12-bit signed samples, 1024 counts per g (2g full scale).
// Notes:   Register offsets, field positions and config and count reset values are defined here; status fields reset to zero in the engine.
package orient_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] ADDR_STATUS = 8'h10;  // Orientation status, read only.
  localparam logic [7:0] ADDR_CONFIG = 8'h11;  // Orientation configuration.
  localparam logic [7:0] ADDR_COUNT  = 8'h12;  // Debounce count value.

  // Field positions in the status and configuration registers.
  localparam int STS_FLAG_BIT = 7;  // Change flag.
  localparam int STS_LOCK_BIT = 6;  // Tilt lockout.
  localparam int STS_CODE_LSB = 1;  // Orientation code, bits 2:1.
  localparam int STS_BF_BIT   = 0;  // Back or front facing.
  localparam int CFG_MODE_BIT = 7;  // Debounce mode select.
  localparam int CFG_EN_BIT   = 6;  // Detection enable.

  // Values after reset.
  localparam logic       CFG_MODE_RST = 1'h1;   // Clear-on-lapse by default.
  localparam logic       CFG_EN_RST   = 1'h0;   // Detection off by default.
  localparam logic [7:0] COUNT_RST    = 8'h00;  // Debounce count after reset.

  // Orientation codes.
  localparam logic [1:0] CODE_UP_NORMAL   = 2'h0;
  localparam logic [1:0] CODE_UP_INVERTED = 2'h1;
  localparam logic [1:0] CODE_SIDE_RIGHT  = 2'h2;
  localparam logic [1:0] CODE_SIDE_LEFT   = 2'h3;

  // Acceleration thresholds in counts at 1024 counts per g.
  localparam logic [11:0] OVERLOAD_LIMIT = 12'h500;  // 1.25g.
  localparam logic [11:0] LOCK_XY_LIMIT  = 12'h1f1;  // Sine of the z-lock angle.

  // Oversampling modes.
  localparam logic [1:0] OSM_NORMAL  = 2'h0;
  localparam logic [1:0] OSM_LOWNOISE = 2'h1;
  localparam logic [1:0] OSM_HIGHRES = 2'h2;
  localparam logic [1:0] OSM_LOWPOWER = 2'h3;

  // Per-rate log2 of debounce steps added per sample, one nibble per rate code.
  localparam logic [31:0] SHIFT_NORMAL   = 32'h5320_0000;
  localparam logic [31:0] SHIFT_LOWNOISE = 32'h3100_0000;
  localparam logic [31:0] SHIFT_HIGHRES  = 32'h8653_2100;
  localparam logic [31:0] SHIFT_LOWPOWER = 32'h2000_0000;

  // Debounce steps that one output sample is worth.
  function automatic logic [8:0] step_weight(input logic [2:0] rate, input logic [1:0] osm);
    logic [31:0] tab;
    tab = SHIFT_NORMAL;
    case (osm)
      OSM_LOWNOISE: tab = SHIFT_LOWNOISE;
      OSM_HIGHRES:  tab = SHIFT_HIGHRES;
      OSM_LOWPOWER: tab = SHIFT_LOWPOWER;
      default:      tab = SHIFT_NORMAL;
    endcase
    return 9'h001 << tab[{rate, 2'h0} +: 4];
  endfunction

  // Magnitude of a signed 12-bit sample; full negative reads as 2048.
  function automatic logic [11:0] mag12(input logic [11:0] v);
    return v[11] ? 12'(~v + 12'h001) : v;
  endfunction

endpackage

/* design/debounce_if.sv */
// Purpose: Carrier between the orientation engine and its debounce counter.
// Assumes: One clock domain.
// Notes:   The engine drives requests, the counter answers.
interface debounce_if;
  logic       step;     // One evaluation this cycle.
  logic       lapse;    // Candidate equals committed state.
  logic       restart;  // Force counter to its initial state.
  logic       mode_clr; // Lapse clears rather than decrements.
  logic [8:0] weight;   // Steps worth of one sample.
  logic [7:0] limit;    // Programmed debounce count.
  logic       done;     // Count reached on this step.
  logic [9:0] level;    // Present counter value.

  modport ctrl    (output step, lapse, restart, mode_clr, weight, limit, input done, level);
  modport counter (input step, lapse, restart, mode_clr, weight, limit, output done, level);
endinterface

/* design/debounce_counter.sv */
// Purpose: Weighted debounce counter for orientation changes.
// Assumes: Limit is at most 255, so the level never exceeds 10 bits.
// Notes:   Done is combinational so the engine commits in the same cycle.
module debounce_counter
(
  input  wire logic   sys_clk_i,
  input  wire logic   rstn_i,
  debounce_if.counter dbif
);
  import orient_pkg::*;

  logic [9:0] level_r;  // Accumulated debounce steps.
  logic [9:0] sum;      // Level after adding this sample's weight.

  // Level plus weight stays under 1024 because the level is below the limit.
  assign sum        = level_r + {1'b0, dbif.weight};
  assign dbif.done  = dbif.step && !dbif.lapse && (sum >= {2'h0, dbif.limit});
  assign dbif.level = level_r;

  // Counter update; a count reached returns it to zero for the next change.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i || dbif.restart)
    begin
      level_r <= 10'h000;
    end
    else if (dbif.step)
    begin
      if (dbif.lapse)
      begin
        // Clear mode drops at once; the other mode backs off one sample.
        if (dbif.mode_clr || (level_r < {1'b0, dbif.weight}))
          level_r <= 10'h000;
        else
          level_r <= level_r - {1'b0, dbif.weight};
      end
      else if (dbif.done)
      begin
        level_r <= 10'h000;
      end
      else
      begin
        level_r <= sum;
      end
    end
  end

endmodule

/* design/orientation_detect_status.sv */
// Purpose: Orientation detection engine with status, config and debounce registers.
// Assumes: Samples and strobes come from logic on sys_clk_i; the serial interface
//          decodes host transfers into the register port.
// Notes:   Register reads answer one cycle after the read strobe.
module orientation_detect_status
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sample_valid_i,
  input  wire logic [11:0] accel_x_i,
  input  wire logic [11:0] accel_y_i,
  input  wire logic [11:0] accel_z_i,
  input  wire logic        active_i,
  input  wire logic        sleep_i,
  input  wire logic [2:0]  output_sample_rate_i,
  input  wire logic [1:0]  oversample_mode_i,
  input  wire logic        orient_irq_enable_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             orient_irq_source_o
);
  import orient_pkg::*;

  debounce_if dbif ();  // Link to the debounce counter.

  // Registers visible to the host.
  logic       debounce_mode_sel_r;     // One clears the counter on lapse.
  logic       orient_detect_enable_r;  // Detection enable.
  logic [7:0] debounce_value_r;        // Programmed debounce count.
  logic       orient_change_flag_r;    // Sticky change flag.
  logic       tilt_lockout_r;          // Committed lockout.
  logic [1:0] orient_code_r;           // Committed orientation code.
  logic       back_front_facing_r;     // Committed facing.
  logic [7:0] rdata_r;                 // Registered read data.

  // Internal state.
  logic       active_q_r;       // Active level one cycle ago.
  logic       sleep_q_r;        // Sleep level one cycle ago.
  logic       first_pending_r;  // First evaluation after activation still due.

  // Candidate classification of the present sample.
  logic [11:0] mag_x;
  logic [11:0] mag_y;
  logic [11:0] mag_z;
  logic        overload;     // Some axis above 1.25g.
  logic        cand_lock;    // Candidate tilt lockout.
  logic [1:0]  cand_code;
  logic        cand_bf;
  logic [3:0]  cand_state;
  logic [3:0]  cur_state;
  logic        eval;         // An evaluation takes place this cycle.
  logic        first_commit; // Evaluation that commits unconditionally.
  logic        commit;       // Candidate replaces the committed state.
  logic        flag_set;     // Change flag is set this cycle.
  logic        status_read;  // Host reads the status register.
  logic        sleep_edge;   // Wake/sleep transition.

  assign mag_x = mag12(accel_x_i);
  assign mag_y = mag12(accel_y_i);
  assign mag_z = mag12(accel_z_i);

  // Above 1.25g the reading is not gravity alone, so the pose is not trusted.
  assign overload = (mag_x > OVERLOAD_LIMIT) || (mag_y > OVERLOAD_LIMIT) ||
                    (mag_z > OVERLOAD_LIMIT);

  // Lockout when the device lies nearly flat and x and y carry little gravity.
  assign cand_lock = (mag_x < LOCK_XY_LIMIT) && (mag_y < LOCK_XY_LIMIT);

  // Facing follows the sign of z: negative z means the back faces up.
  assign cand_bf = accel_z_i[11];

  // Upright when y dominates, sideways when x dominates.
  always_comb
  begin
    if (mag_y >= mag_x)
      cand_code = accel_y_i[11] ? CODE_UP_INVERTED : CODE_UP_NORMAL;
    else
      cand_code = accel_x_i[11] ? CODE_SIDE_LEFT : CODE_SIDE_RIGHT;
  end

  assign cand_state = {cand_bf, cand_code, cand_lock};
  assign cur_state  = {back_front_facing_r, orient_code_r, tilt_lockout_r};

  // One evaluation per sample, only when enabled, active and not overloaded.
  assign eval = sample_valid_i && orient_detect_enable_r && active_i
                && !overload;
  assign first_commit = eval && first_pending_r;
  assign commit       = first_commit || dbif.done;
  assign flag_set     = first_commit || (dbif.done && (cand_state != cur_state));
  assign status_read  = reg_rd_i && (reg_addr_i == ADDR_STATUS);
  assign sleep_edge   = sleep_i != sleep_q_r;

  // Requests to the debounce counter.
  assign dbif.step     = eval && !first_pending_r;
  assign dbif.lapse    = cand_state == cur_state;
  assign dbif.restart  = sleep_edge || first_commit || !orient_detect_enable_r
                         || !active_i;
  assign dbif.mode_clr = debounce_mode_sel_r;
  assign dbif.weight   = step_weight(output_sample_rate_i, oversample_mode_i);
  assign dbif.limit    = debounce_value_r;

  debounce_counter u_debounce
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .dbif      (dbif)
  );

  // Host writes to configuration and count; status is read only.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      debounce_mode_sel_r    <= CFG_MODE_RST;
      orient_detect_enable_r <= CFG_EN_RST;
      debounce_value_r       <= COUNT_RST;
    end
    else if (reg_wr_i && (reg_addr_i == ADDR_CONFIG))
    begin
      debounce_mode_sel_r    <= reg_wdata_i[CFG_MODE_BIT];
      orient_detect_enable_r <= reg_wdata_i[CFG_EN_BIT];
    end
    else if (reg_wr_i && (reg_addr_i == ADDR_COUNT))
    begin
      debounce_value_r <= reg_wdata_i;
    end
  end

  // Committed orientation; it moves even while the flag is still set.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      back_front_facing_r <= 1'b0;
      orient_code_r       <= CODE_UP_NORMAL;
      tilt_lockout_r      <= 1'b0;
    end
    else if (commit)
    begin
      back_front_facing_r <= cand_bf;
      orient_code_r       <= cand_code;
      tilt_lockout_r      <= cand_lock;
    end
  end

  // Sticky change flag; a new change in the read cycle survives the clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      orient_change_flag_r <= 1'b0;
    else if (flag_set)
      orient_change_flag_r <= 1'b1;
    else if (status_read)
      orient_change_flag_r <= 1'b0;
  end

  // Tracks standby to active and wake/sleep edges.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      active_q_r      <= 1'b0;
      sleep_q_r       <= 1'b0;
      first_pending_r <= 1'b0;
    end
    else
    begin
      active_q_r <= active_i;
      sleep_q_r  <= sleep_i;
      if (active_i && !active_q_r)
        first_pending_r <= 1'b1;
      else if (first_commit || !active_i)
        first_pending_r <= 1'b0;
    end
  end

  // Read data, registered; unmapped offsets and reserved bits read zero.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      rdata_r <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_STATUS: rdata_r <= {orient_change_flag_r, tilt_lockout_r, 3'h0,
                                 orient_code_r, back_front_facing_r};
        ADDR_CONFIG: rdata_r <= {debounce_mode_sel_r, orient_detect_enable_r, 6'h00};
        ADDR_COUNT:  rdata_r <= debounce_value_r;
        default:     rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o         = rdata_r;
  // The host learns of a change through this source bit.
  assign orient_irq_source_o = orient_change_flag_r && orient_irq_enable_i;

  // Checks on the engine's behaviour.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_status_read;
    reg_rd_i && (reg_addr_i == ADDR_STATUS);
  endsequence

  sequence s_change_commit;
    dbif.done && (cand_state != cur_state);
  endsequence

  a_flag_on_change: assert property (s_change_commit |=> orient_change_flag_r)
    else $error("Change flag not set after committed change.");
  a_flag_first_eval: assert property (first_commit |=> orient_change_flag_r)
    else $error("Change flag not set on first evaluation.");
  a_read_clears: assert property ((s_status_read and !flag_set) |=> !orient_change_flag_r)
    else $error("Status read did not clear change flag.");
  a_status_fields: assert property (s_status_read |=>
      (reg_rdata_o[5:3] == 3'h0) && (reg_rdata_o[2:1] == $past(orient_code_r))
      && (reg_rdata_o[STS_LOCK_BIT] == $past(tilt_lockout_r)))
    else $error("Status read returned wrong fields.");
  a_overload_hold: assert property ((sample_valid_i && overload) |=> $stable(cur_state))
    else $error("State moved during overload.");
  a_disabled_hold: assert property ((!orient_detect_enable_r) |=> $stable(cur_state))
    else $error("State moved while detection disabled.");
  a_sleep_restart: assert property (sleep_edge |=> (dbif.level == 10'h000))
    else $error("Debounce counter not reset on sleep transition.");
  // A freshly set flag must reach the source bit whenever the enable is up.
  a_irq_source: assert property (flag_set |=> (orient_irq_source_o == orient_irq_enable_i))
    else $error("Source bit disagrees with flag and enable.");
  a_commit_updates: assert property ((dbif.done && !first_commit) ##1 orient_change_flag_r
      |-> cur_state == $past(cand_state))
    else $error("Commit did not update state.");

endmodule

/* verif/host_model.sv */
// Purpose: Host side of the register port, standing in for the serial decoder.
// Assumes: Single byte transfers with one-cycle strobes on sys_clk_i.
// Notes:   Idle address and data lines carry the inverse of their last value.
module host_model
(
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet port at time zero.
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // One strobe, raised just after an edge and dropped after the taking edge.
  task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data);
    @(posedge sys_clk_i);
    #2;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = wr;
    reg_rd_o    = ~wr;
    @(posedge sys_clk_i);
    #2;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    // Released lines must not look like a held value.
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask

  // Writes one byte.
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    access(addr, 1'b1, data);
  endtask

  // Read data is registered at the taking edge and stands until the next read.
  // The host reads status to learn of an orientation event and to clear its flag.
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    access(addr, 1'b0, 8'h00);
    data = reg_rdata_i;
  endtask
endmodule

/* verif/orientation_detect_status_tb_top.sv */
// Purpose: Self-checking bench for the orientation detection engine.
// Assumes: 1024 counts per g; host_model drives the register port.
// Notes:   Each scenario is one task; expected status bytes are worked out by hand.
module orientation_detect_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import orient_pkg::*;

  localparam logic [11:0] P = 12'h400;  // Plus one g.
  localparam logic [11:0] N = 12'hc00;  // Minus one g.

  logic        sys_clk_i;
  logic        rstn_i;
  logic        sample_valid;
  logic [11:0] ax;
  logic [11:0] ay;
  logic [11:0] az;
  logic        active;
  logic        sleep;
  logic [2:0]  rate;
  logic [1:0]  osm;
  logic        irq_en;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        irq_src;
  int          error_cnt;
  int          checks_done;

  orientation_detect_status uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .sample_valid_i(sample_valid), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
    .active_i(active), .sleep_i(sleep), .output_sample_rate_i(rate),
    .oversample_mode_i(osm), .orient_irq_enable_i(irq_en), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .orient_irq_source_o(irq_src));

  host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

  // Free-running 40 MHz clock.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reads a register and compares it.
  task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read(a, d);
    check("register", d, exp);
  endtask

  // One sample pulse, then room for the commit to land.
  task automatic sample(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(posedge sys_clk_i);
    #2;
    ax = x;
    ay = y;
    az = z;
    sample_valid = 1'b1;
    @(posedge sys_clk_i);
    #2;
    sample_valid = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    // Step off the edge so that outputs are looked at once they have settled.
    #2;
  endtask

  task automatic t_reset();
    reg_is(ADDR_STATUS, 8'h00);
    reg_is(ADDR_CONFIG, 8'h80);
    reg_is(ADDR_COUNT, 8'h00);
    host.write(ADDR_COUNT, 8'ha5);
    reg_is(ADDR_COUNT, 8'ha5);
    host.write(ADDR_STATUS, 8'hff);
    reg_is(ADDR_STATUS, 8'h00);
    reg_is(8'h13, 8'h00);
    host.write(ADDR_COUNT, 8'h00);
    $display("reset test done");
  endtask

  // Standby ignores samples; the first evaluation after activation flags.
  task automatic t_first();
    host.write(ADDR_CONFIG, 8'hc0);
    sample(12'h000, P, P);
    reg_is(ADDR_STATUS, 8'h00);
    @(posedge sys_clk_i);
    #2;
    active = 1'b1;
    sample(12'h000, P, P);
    check("irq source", {7'h00, irq_src}, 8'h01);
    reg_is(ADDR_STATUS, 8'h80);
    check("irq source", {7'h00, irq_src}, 8'h00);
    reg_is(ADDR_STATUS, 8'h00);
    $display("first evaluation test done");
  endtask

  // Every code, both facings and lockout; then updates while the flag stands.
  task automatic t_codes();
    logic [43:0] tab [6];
    tab = '{{12'h000, N, P, 8'h82}, {P, 12'h000, P, 8'h84}, {N, 12'h000, P, 8'h86},
            {N, 12'h000, N, 8'h87}, {12'h000, 12'h000, P, 8'hc0}, {12'h000, P, P, 8'h80}};
    for (int i = 0; i < 6; i++)
    begin
      sample(tab[i][43:32], tab[i][31:20], tab[i][19:8]);
      reg_is(ADDR_STATUS, tab[i][7:0]);
    end
    irq_en = 1'b0;
    sample(12'h000, N, P);
    sample(P, 12'h000, P);
    check("irq source", {7'h00, irq_src}, 8'h00);
    reg_is(ADDR_STATUS, 8'h84);
    irq_en = 1'b1;
    $display("code test done");
  endtask

  // Overload holds the state; exactly 1.25g is still taken; disable holds too.
  task automatic t_hold();
    sample(12'h000, 12'h578, N);
    reg_is(ADDR_STATUS, 8'h04);
    sample(12'h000, 12'h500, N);
    reg_is(ADDR_STATUS, 8'h81);
    host.write(ADDR_CONFIG, 8'h80);
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h01);
    $display("hold test done");
  endtask

  // Count 3 with a lapse in the run: clearing needs three more, decrementing two.
  task automatic t_debounce();
    host.write(ADDR_COUNT, 8'h03);
    host.write(ADDR_CONFIG, 8'hc0);
    sample(P, 12'h000, P);
    sample(P, 12'h000, P);
    sample(12'h000, P, N);
    sample(P, 12'h000, P);
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h01);
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h84);
    host.write(ADDR_CONFIG, 8'h40);
    sample(12'h000, P, N);
    sample(12'h000, P, N);
    sample(P, 12'h000, P);
    sample(12'h000, P, N);
    sample(12'h000, P, N);
    reg_is(ADDR_STATUS, 8'h81);
    $display("debounce test done");
  endtask

  // Step weight: high resolution at rate 2 counts double, normal counts single.
  task automatic t_weight();
    host.write(ADDR_COUNT, 8'h02);
    rate = 3'h2;
    osm = OSM_HIGHRES;
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h84);
    osm = OSM_NORMAL;
    sample(12'h000, P, N);
    reg_is(ADDR_STATUS, 8'h04);
    sample(12'h000, P, N);
    reg_is(ADDR_STATUS, 8'h81);
    $display("weight test done");
  endtask

  // A sleep change between samples throws away the partial count.
  task automatic t_sleep();
    sample(P, 12'h000, P);
    @(posedge sys_clk_i);
    #2;
    sleep = 1'b1;
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h01);
    sample(P, 12'h000, P);
    reg_is(ADDR_STATUS, 8'h84);
    $display("sleep test done");
  endtask

  // The single place where the run ends.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short and counts it as a mismatch.
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    summarize();
  end

  // Main sequence: inputs quiet, ten cycles of reset, then the scenarios.
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    sample_valid = 1'b0;
    ax = 12'h000;
    ay = 12'h000;
    az = 12'h000;
    active = 1'b0;
    sleep = 1'b0;
    rate = 3'h0;
    osm = OSM_NORMAL;
    irq_en = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    #2;
    rstn_i = 1'b1;
    t_reset();
    t_first();
    t_codes();
    t_hold();
    t_debounce();
    t_weight();
    t_sleep();
    summarize();
  end
endmodule
